// ===== tb_tm8_timer.sv
// Self-checking bench for the 8-bit timer block driven over APB
`timescale 1ns/1ps
`default_nettype none
module tb_tm8_timer;
	import tm8_pkg::*;
	logic                   pclk           = 1'b0;
	logic                   presetn        = 1'b0;
	logic [TM8_PADDR_W-1:0] paddr          = '0;
	logic                   psel           = 1'b0;
	logic                   penable        = 1'b0;
	logic                   pwrite         = 1'b0;
	logic [31:0]            pwdata         = '0;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	logic                   ext_count_pin  = 1'b0;
	logic                   cpu_irq_enable = 1'b0;
	logic [2:0]             vector_ack     = 3'b000;
	logic [2:0]             irq_req;
	logic                   wave_out_a;
	logic                   wave_out_b;
	logic                   wave_conn_a;
	logic                   wave_conn_b;
	int                     failures       = 0;
	int                     cmp_count      = 0;
	logic [31:0]            rdat;
	logic                   rerr;
	logic [7:0]             regs [7]       = '{TM8_IDX_CMP_B, TM8_IDX_CMP_A, TM8_IDX_COUNT,
		TM8_IDX_CTRL_B, TM8_IDX_CTRL_A, TM8_IDX_FLAGS, TM8_IDX_MASK};
	logic [1:0]             com_seq [5]    = '{2'b01, 2'b01, 2'b11, 2'b10, 2'b00};
	logic                   wave_exp [5]   = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
	int                     divs [5]       = '{1, 8, 64, 256, 1024};

	always #10 pclk = ~pclk;

	tm8_timer dut (
		.pclk           (pclk),
		.presetn        (presetn),
		.paddr          (paddr),
		.psel           (psel),
		.penable        (penable),
		.pwrite         (pwrite),
		.pwdata         (pwdata),
		.prdata         (prdata),
		.pready         (pready),
		.pslverr        (pslverr),
		.ext_count_pin  (ext_count_pin),
		.cpu_irq_enable (cpu_irq_enable),
		.vector_ack     (vector_ack),
		.irq_req        (irq_req),
		.wave_out_a     (wave_out_a),
		.wave_out_b     (wave_out_b),
		.wave_conn_a    (wave_conn_a),
		.wave_conn_b    (wave_conn_b)
	);

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One idle cycle between transfers keeps each strobe edge distinct
	task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= {2'b00, idx, 2'b00};
		pwrite  <= wr;
		pwdata  <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 16)
		begin
			@(posedge pclk);
			n++;
		end
		if (pready !== 1'b1)
		begin
			failures++;
			$display("[ERR] pready expected 1 seen %b", pready);
			print_verdict();
		end
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(idx, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] idx, input string name, input logic [31:0] exp);
		apb(idx, 1'b0, 8'h00);
		chk(name, exp, rdat);
	endtask

	// Run the counter for a while, then stop it again
	task automatic run(input logic [7:0] code, input int cycles);
		wr(TM8_IDX_CTRL_B, code);
		repeat (cycles) @(posedge pclk);
		wr(TM8_IDX_CTRL_B, 8'h00);
	endtask

	task automatic ack(input logic [2:0] v);
		@(posedge pclk);
		vector_ack <= v;
		@(posedge pclk);
		vector_ack <= 3'b000;
	endtask

	task automatic pulses(input int n);
		repeat (n)
		begin
			@(posedge pclk);
			ext_count_pin <= 1'b1;
			repeat (4) @(posedge pclk);
			ext_count_pin <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		repeat (4) @(posedge pclk);
	endtask

	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++)
			rd(regs[i], "reset value", 32'h0);
		wr(TM8_IDX_MASK, 8'hff);
		rd(TM8_IDX_MASK, "mask readback", 32'hbf);
		wr(TM8_IDX_CTRL_B, 8'hff);
		rd(TM8_IDX_CTRL_B, "ctrl_b readback", 32'h0f);
		wr(TM8_IDX_CTRL_B, 8'h00);
		wr(TM8_IDX_CMP_A, 8'h5a);
		rd(TM8_IDX_CMP_A, "compare_val_a", 32'h5a);
		wr(TM8_IDX_CMP_B, 8'ha5);
		rd(TM8_IDX_CMP_B, "compare_val_b", 32'ha5);
		rd(8'h20, "unmapped read", 32'h0);
		chk("pslverr", 32'h1, 32'(rerr));
		$display("test registers done");

		// Forced compares in clear-on-match mode with the counter stopped
		wr(TM8_IDX_MASK, 8'h07);
		cpu_irq_enable <= 1'b1;
		wr(TM8_IDX_COUNT, 8'h33);
		for (int i = 0; i < 5; i++)
		begin
			wr(TM8_IDX_CTRL_A, {com_seq[i], 2'b11, 2'b00, 2'b10});
			wr(TM8_IDX_CTRL_B, 8'hc0);
			repeat (3) @(posedge pclk);
			chk("wave_conn_a", 32'(com_seq[i] != 2'b00), 32'(wave_conn_a));
			if (com_seq[i] != 2'b00)
				chk("wave_out_a", 32'(wave_exp[i]), 32'(wave_out_a));
		end
		chk("wave_out_b", 32'h1, 32'(wave_out_b));
		chk("wave_conn_b", 32'h1, 32'(wave_conn_b));
		chk("irq_req", 32'h0, 32'(irq_req));
		rd(TM8_IDX_COUNT, "count after force", 32'h33);
		rd(TM8_IDX_FLAGS, "flags after force", 32'h0);
		rd(TM8_IDX_CTRL_B, "force bits", 32'h0);
		// Phase-correct mode: force strobes must be ignored
		wr(TM8_IDX_CTRL_A, 8'he1);
		wr(TM8_IDX_CTRL_B, 8'hc0);
		repeat (3) @(posedge pclk);
		chk("wave_out_a pwm", 32'h0, 32'(wave_out_a));
		chk("wave_out_b pwm", 32'h1, 32'(wave_out_b));
		wr(TM8_IDX_CTRL_B, 8'h00);
		wr(TM8_IDX_CTRL_A, 8'h00);
		$display("test force done");

		wr(TM8_IDX_CMP_A, 8'h05);
		wr(TM8_IDX_CMP_B, 8'h0a);
		wr(TM8_IDX_COUNT, 8'h00);
		run(8'h01, 16);
		rd(TM8_IDX_FLAGS, "match flags", 32'h06);
		chk("irq_req", 32'h6, 32'(irq_req));
		wr(TM8_IDX_MASK, 8'h03);
		// Mask lands at the write edge; look one edge later
		@(posedge pclk);
		chk("irq_req masked", 32'h2, 32'(irq_req));
		cpu_irq_enable <= 1'b0;
		@(posedge pclk);
		chk("irq_req global off", 32'h0, 32'(irq_req));
		wr(TM8_IDX_FLAGS, 8'h02);
		rd(TM8_IDX_FLAGS, "flag a write-one", 32'h04);
		ack(3'b100);
		rd(TM8_IDX_FLAGS, "flag b vector", 32'h00);
		$display("test compare done");

		cpu_irq_enable <= 1'b1;
		wr(TM8_IDX_COUNT, 8'hfa);
		run(8'h01, 12);
		rd(TM8_IDX_FLAGS, "overflow flags", 32'h03);
		chk("ovf_flag", 32'h1, 32'(rdat[0]));
		chk("ovf irq", 32'h1, 32'(irq_req[0]));
		ack(3'b001);
		rd(TM8_IDX_FLAGS, "overflow vector", 32'h02);
		chk("ovf cleared", 32'h0, 32'(rdat[0]));
		ack(3'b010);
		rd(TM8_IDX_FLAGS, "flag a vector", 32'h00);
		$display("test overflow done");

		// A counter write hides a match on the very next tick only
		wr(TM8_IDX_FLAGS, 8'h07);
		wr(TM8_IDX_CMP_A, 8'h20);
		wr(TM8_IDX_COUNT, 8'h20);
		run(8'h01, 4);
		rd(TM8_IDX_FLAGS, "blocked match", 32'h00);
		wr(TM8_IDX_COUNT, 8'h1f);
		run(8'h01, 4);
		rd(TM8_IDX_FLAGS, "later match", 32'h02);
		$display("test counter write done");

		// Up-down counting with compare A as top: overflow at bottom
		wr(TM8_IDX_FLAGS, 8'h07);
		wr(TM8_IDX_CMP_A, 8'h04);
		wr(TM8_IDX_COUNT, 8'h00);
		wr(TM8_IDX_CTRL_A, 8'h01);
		run(8'h09, 6);
		rd(TM8_IDX_FLAGS, "bottom overflow", 32'h03);
		rd(TM8_IDX_COUNT, "up-down count", 32'h02);
		wr(TM8_IDX_CTRL_A, 8'h00);
		$display("test phase correct done");

		for (int i = 0; i < 5; i++)
		begin
			wr(TM8_IDX_COUNT, 8'h00);
			run(8'(i + 1), 10 * divs[i] - 4);
			apb(TM8_IDX_COUNT, 1'b0, 8'h00);
			cmp_count++;
			if ((^rdat) === 1'bx || rdat < 32'd8 || rdat > 32'd12)
			begin
				failures++;
				$display("[ERR] prescaled count expected 10 seen %h", rdat);
			end
		end
		wr(TM8_IDX_COUNT, 8'h44);
		repeat (50) @(posedge pclk);
		rd(TM8_IDX_COUNT, "stopped count", 32'h44);
		$display("test prescaler done");

		for (int c = 7; c >= 6; c--)
		begin
			wr(TM8_IDX_COUNT, 8'h00);
			wr(TM8_IDX_CTRL_B, 8'(c));
			pulses(5);
			wr(TM8_IDX_CTRL_B, 8'h00);
			rd(TM8_IDX_COUNT, "pin count", 32'h05);
		end
		$display("test external pin done");
		print_verdict();
	end
endmodule
`default_nettype wire

// ===== tm8_clk_select.sv
// Prescaler and clock-source selection producing the timer tick
`timescale 1ns/1ps
`default_nettype none
module tm8_clk_select (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire tm8_pkg::tm8_clk_sel_t clock_sel,
	input  wire logic                  ext_count_pin,
	output logic                       tick
);
	import tm8_pkg::*;

	tm8_pre_state_t q;
	tm8_pre_state_t d;

	function automatic logic low_ones(input logic [TM8_PRE_W-1:0] v, input int n);
		logic [TM8_PRE_W-1:0] m;
		m = {TM8_PRE_W{1'b1}} >> (TM8_PRE_W - n);
		low_ones = &(v | ~m);
	endfunction

	always_comb
	begin
		d = q;
		d.pre = q.pre + 1'b1;
		// Pin passes two flops; edge detect looks only at the second and later
		d.sync = {q.sync[0], ext_count_pin};
		d.prev = q.sync[1];
	end

	always_comb
	begin
		case (clock_sel)
			CS_STOP:     tick = 1'b0;
			CS_DIV1:     tick = 1'b1;
			CS_DIV8:     tick = low_ones(q.pre, TM8_DIV8_BITS);
			CS_DIV64:    tick = low_ones(q.pre, TM8_DIV64_BITS);
			CS_DIV256:   tick = low_ones(q.pre, TM8_DIV256_BITS);
			CS_DIV1024:  tick = low_ones(q.pre, TM8_DIV1024_BITS);
			// Pin is sampled regardless of its direction setting
			CS_EXT_FALL: tick = q.prev & ~q.sync[1];
			CS_EXT_RISE: tick = ~q.prev & q.sync[1];
			default:     tick = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else
			q <= d;
	end

	property p_stop_no_tick;
		@(posedge pclk) disable iff (!presetn)
		(clock_sel == CS_STOP)[*2] |-> !tick;
	endproperty
	a_stop_no_tick: assert property (p_stop_no_tick) else $error("tick while stopped");

	property p_div8_gap;
		@(posedge pclk) disable iff (!presetn)
		(clock_sel == CS_DIV8 && tick) ##1 (clock_sel == CS_DIV8)[*7] |-> !tick;
	endproperty
	a_div8_gap: assert property (p_div8_gap) else $error("div8 ticks too close");

	property p_ext_rise;
		@(posedge pclk) disable iff (!presetn)
		(clock_sel == CS_EXT_RISE && $rose(ext_count_pin))
			##1 (ext_count_pin && clock_sel == CS_EXT_RISE) |=> tick;
	endproperty
	a_ext_rise: assert property (p_ext_rise) else $error("pin edge not counted");

endmodule
`default_nettype wire

// ===== tm8_pkg.sv
// Shared constants, encodings and state types of the 8-bit timer block
package tm8_pkg;

	localparam int          TM8_PADDR_W     = 12;
	// Register indices; byte address is four times the index
	localparam logic [7:0]  TM8_IDX_CMP_B   = 8'h15;
	localparam logic [7:0]  TM8_IDX_CMP_A   = 8'h16;
	localparam logic [7:0]  TM8_IDX_COUNT   = 8'h17;
	localparam logic [7:0]  TM8_IDX_CTRL_B  = 8'h18;
	localparam logic [7:0]  TM8_IDX_CTRL_A  = 8'h19;
	localparam logic [7:0]  TM8_IDX_FLAGS   = 8'h25;
	localparam logic [7:0]  TM8_IDX_MASK    = 8'h26;

	localparam int          TM8_COM_A_LSB   = 6;
	localparam int          TM8_COM_B_LSB   = 4;
	localparam int          TM8_WGM_LSB     = 0;
	localparam int          TM8_FOC_A_BIT   = 7;
	localparam int          TM8_FOC_B_BIT   = 6;
	localparam int          TM8_WGM2_BIT    = 3;
	localparam int          TM8_CS_LSB      = 0;
	localparam int          TM8_FLAG_OVF    = 0;
	localparam int          TM8_FLAG_CMP_A  = 1;
	localparam int          TM8_FLAG_CMP_B  = 2;
	localparam int          TM8_RSV_BIT     = 6;

	localparam logic [7:0]  TM8_CTRLA_WMASK = 8'hf3;
	localparam logic [7:0]  TM8_CTRLB_WMASK = 8'h0f;
	localparam logic [7:0]  TM8_MASK_WMASK  = 8'hbf;
	localparam logic [7:0]  TM8_REG_RESET   = 8'h00;
	localparam logic [7:0]  TM8_MAX         = 8'hff;
	localparam logic [7:0]  TM8_BOTTOM      = 8'h00;

	localparam int          TM8_PRE_W       = 10;
	localparam int          TM8_DIV8_BITS   = 3;
	localparam int          TM8_DIV64_BITS  = 6;
	localparam int          TM8_DIV256_BITS = 8;
	localparam int          TM8_DIV1024_BITS = 10;

	typedef enum logic [2:0] {
		CS_STOP     = 3'b000,
		CS_DIV1     = 3'b001,
		CS_DIV8     = 3'b010,
		CS_DIV64    = 3'b011,
		CS_DIV256   = 3'b100,
		CS_DIV1024  = 3'b101,
		CS_EXT_FALL = 3'b110,
		CS_EXT_RISE = 3'b111
	} tm8_clk_sel_t;

	typedef enum logic [2:0] {
		WM_NORMAL    = 3'b000,
		WM_PC_FF     = 3'b001,
		WM_CTC       = 3'b010,
		WM_FAST_FF   = 3'b011,
		WM_RSV4      = 3'b100,
		WM_PC_OCRA   = 3'b101,
		WM_RSV6      = 3'b110,
		WM_FAST_OCRA = 3'b111
	} tm8_wave_mode_t;

	typedef enum logic [1:0] {
		COM_OFF    = 2'b00,
		COM_TOGGLE = 2'b01,
		COM_CLEAR  = 2'b10,
		COM_SET    = 2'b11
	} tm8_com_t;

	typedef struct packed {
		logic [TM8_PRE_W-1:0] pre;
		logic [1:0]           sync;
		logic                 prev;
	} tm8_pre_state_t;

	typedef struct packed {
		logic [7:0]  ctrl_a;
		logic [7:0]  ctrl_b;
		logic [7:0]  count_value;
		logic [7:0]  compare_val_a;
		logic [7:0]  compare_val_b;
		logic [2:0]  flags;
		logic [7:0]  mask;
		logic        down;
		logic        block;
		logic        wave_a;
		logic        wave_b;
		logic        force_a;
		logic        force_b;
		logic        ack;
		logic [31:0] prdata;
	} tm8_core_state_t;

endpackage

// ===== tm8_timer.sv
// Timer/counter control, counter, compare, waveform and flag logic with APB slave
`timescale 1ns/1ps
`default_nettype none
module tm8_timer (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic [tm8_pkg::TM8_PADDR_W-1:0] paddr,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         ext_count_pin,
	input  wire logic                         cpu_irq_enable,
	input  wire logic [2:0]                   vector_ack,
	output logic      [2:0]                   irq_req,
	output logic                              wave_out_a,
	output logic                              wave_out_b,
	output logic                              wave_conn_a,
	output logic                              wave_conn_b
);
	import tm8_pkg::*;

	tm8_core_state_t q;
	tm8_core_state_t d;

	logic           tick;
	logic           acc;
	logic           wr;
	logic           match_a;
	logic           match_b;
	logic           ovf;
	logic           at_top;
	logic [7:0]     top;
	tm8_wave_mode_t mode;
	tm8_com_t       com_a;
	tm8_com_t       com_b;

	function automatic logic hit(input logic [TM8_PADDR_W-1:0] a, input logic [7:0] idx);
		hit = (a[TM8_PADDR_W-1:2] == {{(TM8_PADDR_W-10){1'b0}}, idx}) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic is_pwm(input logic [2:0] m);
		is_pwm = (m == WM_PC_FF) || (m == WM_FAST_FF) || (m == WM_PC_OCRA) || (m == WM_FAST_OCRA);
	endfunction

	function automatic logic is_pc(input logic [2:0] m);
		is_pc = (m == WM_PC_FF) || (m == WM_PC_OCRA);
	endfunction

	// Next level of one waveform output
	function automatic logic wave_next(input logic cur, input tm8_com_t com, input logic [2:0] m,
		input logic match, input logic force_cmp, input logic wrap, input logic down,
		input logic may_toggle);
		logic r;
		r = cur;
		if (!is_pwm(m))
		begin
			if (match || force_cmp)
			begin
				case (com)
					COM_TOGGLE: r = ~cur;
					COM_CLEAR:  r = 1'b0;
					COM_SET:    r = 1'b1;
					default:    r = cur;
				endcase
			end
		end
		else if (com == COM_TOGGLE)
		begin
			if (match && may_toggle)
				r = ~cur;
		end
		else if (com[1])
		begin
			if (is_pc(m))
			begin
				if (match)
					r = com[0] ^ down;
			end
			else if (wrap)
				r = ~com[0];
			else if (match)
				r = com[0];
		end
		wave_next = r;
	endfunction

	function automatic logic [7:0] read_mux(input logic [TM8_PADDR_W-1:0] a, input tm8_core_state_t s);
		logic [7:0] r;
		r = 8'h00;
		if (hit(a, TM8_IDX_CTRL_A))
			r = s.ctrl_a;
		if (hit(a, TM8_IDX_CTRL_B))
			r = s.ctrl_b & TM8_CTRLB_WMASK;
		if (hit(a, TM8_IDX_COUNT))
			r = s.count_value;
		if (hit(a, TM8_IDX_CMP_A))
			r = s.compare_val_a;
		if (hit(a, TM8_IDX_CMP_B))
			r = s.compare_val_b;
		if (hit(a, TM8_IDX_FLAGS))
			r = {5'h00, s.flags};
		if (hit(a, TM8_IDX_MASK))
			r = s.mask & TM8_MASK_WMASK;
		read_mux = r;
	endfunction

	function automatic logic mapped(input logic [TM8_PADDR_W-1:0] a);
		mapped = hit(a, TM8_IDX_CTRL_A) || hit(a, TM8_IDX_CTRL_B) || hit(a, TM8_IDX_COUNT)
			|| hit(a, TM8_IDX_CMP_A) || hit(a, TM8_IDX_CMP_B) || hit(a, TM8_IDX_FLAGS)
			|| hit(a, TM8_IDX_MASK);
	endfunction

	tm8_clk_select u_clk_select (
		.pclk          (pclk),
		.presetn       (presetn),
		.clock_sel     (tm8_clk_sel_t'(q.ctrl_b[TM8_CS_LSB +: 3])),
		.ext_count_pin (ext_count_pin),
		.tick          (tick)
	);

	assign mode  = tm8_wave_mode_t'({q.ctrl_b[TM8_WGM2_BIT], q.ctrl_a[TM8_WGM_LSB +: 2]});
	assign com_a = tm8_com_t'(q.ctrl_a[TM8_COM_A_LSB +: 2]);
	assign com_b = tm8_com_t'(q.ctrl_a[TM8_COM_B_LSB +: 2]);
	assign top   = (mode == WM_CTC || mode == WM_PC_OCRA || mode == WM_FAST_OCRA)
		? q.compare_val_a : TM8_MAX;
	assign at_top = (q.count_value == top);

	// One wait state so that read data comes from a flop
	assign acc     = psel & penable;
	assign pready  = acc & q.ack;
	assign pslverr = pready & ~mapped(paddr);
	assign wr      = pready & pwrite;
	assign prdata  = q.prdata;

	// Only real counter matches count; a force never reaches these
	assign match_a = tick & ~q.block & (q.count_value == q.compare_val_a);
	assign match_b = tick & ~q.block & (q.count_value == q.compare_val_b);

	always_comb
	begin
		ovf = 1'b0;
		if (tick)
		begin
			if (is_pc(mode))
				ovf = q.down && (q.count_value == TM8_BOTTOM);
			else if (mode == WM_FAST_OCRA)
				ovf = at_top;
			else
				ovf = (q.count_value == TM8_MAX);
		end
	end

	always_comb
	begin
		d = q;
		d.ack = acc & ~q.ack;
		d.force_a = 1'b0;
		d.force_b = 1'b0;
		if (acc && !q.ack && !pwrite)
			d.prdata = {24'h000000, read_mux(paddr, q)};

		// Counting sequence
		if (tick)
		begin
			d.block = 1'b0;
			if (is_pc(mode))
			begin
				if (!q.down)
				begin
					if (at_top)
					begin
						d.down = 1'b1;
						d.count_value = q.count_value - 1'b1;
					end
					else
						d.count_value = q.count_value + 1'b1;
				end
				else if (q.count_value == TM8_BOTTOM)
				begin
					d.down = 1'b0;
					d.count_value = q.count_value + 1'b1;
				end
				else
					d.count_value = q.count_value - 1'b1;
			end
			else if (at_top)
				d.count_value = TM8_BOTTOM;
			else
				d.count_value = q.count_value + 1'b1;
		end

		d.wave_a = wave_next(q.wave_a, com_a, mode, match_a, q.force_a, tick & at_top, q.down,
			q.ctrl_b[TM8_WGM2_BIT]);
		d.wave_b = wave_next(q.wave_b, com_b, mode, match_b, q.force_b, tick & at_top, q.down,
			1'b0);

		// Hardware set beats a same-cycle clear
		d.flags = q.flags & ~vector_ack;
		if (wr && hit(paddr, TM8_IDX_FLAGS))
			d.flags = d.flags & ~pwdata[2:0];
		d.flags[TM8_FLAG_OVF]   = d.flags[TM8_FLAG_OVF] | ovf;
		d.flags[TM8_FLAG_CMP_A] = d.flags[TM8_FLAG_CMP_A] | match_a;
		d.flags[TM8_FLAG_CMP_B] = d.flags[TM8_FLAG_CMP_B] | match_b;

		if (wr)
		begin
			if (hit(paddr, TM8_IDX_CTRL_A))
				d.ctrl_a = pwdata[7:0] & TM8_CTRLA_WMASK;
			if (hit(paddr, TM8_IDX_CTRL_B))
			begin
				d.ctrl_b = pwdata[7:0] & TM8_CTRLB_WMASK;
				if (!is_pwm({pwdata[TM8_WGM2_BIT], q.ctrl_a[TM8_WGM_LSB +: 2]}))
				begin
					d.force_a = pwdata[TM8_FOC_A_BIT];
					d.force_b = pwdata[TM8_FOC_B_BIT];
				end
			end
			// CPU write overrides counting and masks a match on the next timer tick
			if (hit(paddr, TM8_IDX_COUNT))
			begin
				d.count_value = pwdata[7:0];
				d.block = 1'b1;
			end
			if (hit(paddr, TM8_IDX_CMP_A))
				d.compare_val_a = pwdata[7:0];
			if (hit(paddr, TM8_IDX_CMP_B))
				d.compare_val_b = pwdata[7:0];
			if (hit(paddr, TM8_IDX_MASK))
				d.mask = pwdata[7:0] & TM8_MASK_WMASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else
			q <= d;
	end

	assign irq_req     = q.flags & q.mask[2:0] & {3{cpu_irq_enable}};
	assign wave_out_a  = q.wave_a;
	assign wave_out_b  = q.wave_b;
	assign wave_conn_a = (com_a != COM_OFF);
	assign wave_conn_b = (com_b != COM_OFF);

	sequence s_ctrlb_wr_pwm;
		wr && hit(paddr, TM8_IDX_CTRL_B)
			&& is_pwm({pwdata[TM8_WGM2_BIT], q.ctrl_a[TM8_WGM_LSB +: 2]});
	endsequence

	property p_force_a_pwm;
		@(posedge pclk) disable iff (!presetn)
		s_ctrlb_wr_pwm |=> !q.force_a ##1 (q.wave_a == $past(q.wave_a) || match_a || tick);
	endproperty
	a_force_a_pwm: assert property (p_force_a_pwm) else $error("force A acted in PWM mode");

	property p_force_b_pwm;
		@(posedge pclk) disable iff (!presetn)
		s_ctrlb_wr_pwm |=> !q.force_b;
	endproperty
	a_force_b_pwm: assert property (p_force_b_pwm) else $error("force B acted in PWM mode");

	property p_force_pulse;
		@(posedge pclk) disable iff (!presetn)
		q.force_a |=> !q.force_a;
	endproperty
	a_force_pulse: assert property (p_force_pulse) else $error("force strobe held");

	property p_force_set_out;
		@(posedge pclk) disable iff (!presetn)
		(q.force_a && !is_pwm(mode) && com_a == COM_SET) |=> q.wave_a;
	endproperty
	a_force_set_out: assert property (p_force_set_out) else $error("forced set missed");

	property p_force_no_flag;
		@(posedge pclk) disable iff (!presetn)
		(q.force_b && !match_b) |=> !$rose(q.flags[TM8_FLAG_CMP_B]);
	endproperty
	a_force_no_flag: assert property (p_force_no_flag) else $error("force set a flag");

	property p_ctrlb_read;
		@(posedge pclk) disable iff (!presetn)
		(acc && !q.ack && !pwrite && hit(paddr, TM8_IDX_CTRL_B)) |=> (prdata[7:4] == 4'h0) && pready;
	endproperty
	a_ctrlb_read: assert property (p_ctrlb_read) else $error("ctrl B high bits nonzero");

	property p_mask_rsv;
		@(posedge pclk) disable iff (!presetn)
		(acc && !q.ack && !pwrite && hit(paddr, TM8_IDX_MASK)) |=> !prdata[TM8_RSV_BIT];
	endproperty
	a_mask_rsv: assert property (p_mask_rsv) else $error("reserved mask bit read one");

	property p_cnt_block;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit(paddr, TM8_IDX_COUNT)) |=> q.block && !match_a && !match_b;
	endproperty
	a_cnt_block: assert property (p_cnt_block) else $error("match after counter write");

	// Block must survive idle cycles until the next timer tick consumes it
	property p_block_hold;
		@(posedge pclk) disable iff (!presetn)
		(q.block && !tick) |=> q.block;
	endproperty
	a_block_hold: assert property (p_block_hold) else $error("match block lost early");

	property p_match_b_flag;
		@(posedge pclk) disable iff (!presetn)
		match_b |=> q.flags[TM8_FLAG_CMP_B];
	endproperty
	a_match_b_flag: assert property (p_match_b_flag) else $error("flag B not set");

	property p_ovf_normal;
		@(posedge pclk) disable iff (!presetn)
		(tick && mode == WM_NORMAL && q.count_value == TM8_MAX
			&& !(wr && hit(paddr, TM8_IDX_COUNT))) |=> q.flags[TM8_FLAG_OVF]
			&& q.count_value == TM8_BOTTOM;
	endproperty
	a_ovf_normal: assert property (p_ovf_normal) else $error("overflow at MAX missed");

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		($rose(q.flags[TM8_FLAG_CMP_A]) && q.mask[TM8_FLAG_CMP_A] && cpu_irq_enable)
			|-> irq_req[TM8_FLAG_CMP_A];
	endproperty
	a_irq: assert property (p_irq) else $error("compare A interrupt missing");

	property p_toggle;
		@(posedge pclk) disable iff (!presetn)
		(match_a && !is_pwm(mode) && com_a == COM_TOGGLE) |=> q.wave_a != $past(q.wave_a);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle on match missed");

endmodule
`default_nettype wire
